// [hw/qbp_params.svh]
// qbp_params.svh: port widths, reset values, bit positions and timing counts of the port block
`ifndef QBP_PARAMS_SVH
`define QBP_PARAMS_SVH

// ----------------------------------------------------------------------------
// port widths
// ----------------------------------------------------------------------------
`define QBP_P1_W 8
`define QBP_P3_W 8
`define QBP_P4_W 5
`define QBP_BUS_W 8

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define QBP_LATCH_RST 8'hff
`define QBP_RDATA_RST 8'h00
`define QBP_ALT_IN_IDLE 1'b1

// ----------------------------------------------------------------------------
// port 3 bit positions
// ----------------------------------------------------------------------------
`define QBP_P3_SER_RX 0
`define QBP_P3_SER_TX 1
`define QBP_P3_IRQ0 2
`define QBP_P3_IRQ1 3
`define QBP_P3_T0 4
`define QBP_P3_T1_SS 5
`define QBP_P3_WR 6
`define QBP_P3_RD 7
`define QBP_P3_FORCE_MASK 8'h42

// ----------------------------------------------------------------------------
// port 4 bit positions
// ----------------------------------------------------------------------------
`define QBP_P4_CAN_TX 0
`define QBP_P4_CAN_RX 1
`define QBP_P4_MISO 2
`define QBP_P4_SCK 3
`define QBP_P4_MOSI 4

// ----------------------------------------------------------------------------
// strong pull-up timing
// ----------------------------------------------------------------------------
`define QBP_CLK_PS 8000
`define QBP_OSC_PS 8000
`define QBP_BOOST_OSC 2
`define QBP_BOOST_CYC (((`QBP_BOOST_OSC * `QBP_OSC_PS) + `QBP_CLK_PS - 1) / `QBP_CLK_PS)

`endif

// [hw/qbp_pkg.sv]
// qbp_pkg.sv: types and shared functions of the port block
package qbp_pkg;

  // --------------------------------------------------------------------------
  // port selection on the internal bus
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    QBP_SEL_P1 = 2'h0,
    QBP_SEL_P3 = 2'h1,
    QBP_SEL_P4 = 2'h2,
    QBP_SEL_NONE = 2'h3
  } qbp_sel_t;

  // --------------------------------------------------------------------------
  // an alternate input only sees the pin while its latch bit is set
  // --------------------------------------------------------------------------
  function automatic logic qbp_gate(input logic latch_bit, input logic pin_bit);
    return latch_bit ? pin_bit : 1'b1;
  endfunction

endpackage

// [hw/qbp_drv_if.sv]
// qbp_drv_if.sv: carrier between the port core and one pin driver bank
interface qbp_drv_if #(
  parameter int W = 8
);
  logic [W-1:0] latch;
  logic [W-1:0] alt_val;
  logic [W-1:0] pin_o;
  logic [W-1:0] pin_oe_n;
  logic [W-1:0] weak_pu;
  logic [W-1:0] boost;

  modport core (
    output latch,
    output alt_val,
    input pin_o,
    input pin_oe_n,
    input weak_pu,
    input boost
  );

  modport drv (
    input latch,
    input alt_val,
    output pin_o,
    output pin_oe_n,
    output weak_pu,
    output boost
  );
endinterface

// [hw/qbp_sync.sv]
// qbp_sync.sv: two-stage pin synchroniser bank
module qbp_sync #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      stage1 <= '1;
      sync_o <= '1;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule // qbp_sync

// [hw/qbp_pin_drv.sv]
// qbp_pin_drv.sv: quasi-bidirectional pin drivers with zero-to-one boost
`include "qbp_params.svh"

module qbp_pin_drv #(
  parameter int W = 8,
  parameter int BOOST_CYC = `QBP_BOOST_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  qbp_drv_if.drv port_if
);

  localparam int CW = $clog2(BOOST_CYC + 1);

  logic [W-1:0] val;
  logic [W-1:0] rise;
  logic [W-1:0] drv_q;
  logic [W-1:0] next_boost;
  logic [CW-1:0] cnt [W];
  logic [CW-1:0] next_cnt [W];

  // pin level is latch and alternate output together
  assign val = port_if.latch & port_if.alt_val;
  assign rise = val & ~drv_q;

  // per-bit boost counter, restarted on each zero-to-one step
  always_comb begin
    for (int b = 0; b < W; b++) begin
      next_cnt[b] = cnt[b];
      if (rise[b]) begin
        next_cnt[b] = CW'(BOOST_CYC);
      end else if (cnt[b] != '0) begin
        next_cnt[b] = cnt[b] - 1'b1;
      end
      next_boost[b] = (next_cnt[b] != '0);
    end
  end

  // registered pin drive: low drives, high is driven during boost, then released to the weak pull-up
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      drv_q <= '1;
      port_if.pin_o <= '1;
      port_if.pin_oe_n <= '1;
      port_if.weak_pu <= '1;
      port_if.boost <= '0;
      for (int b = 0; b < W; b++) begin
        cnt[b] <= '0;
      end
    end else begin
      drv_q <= val;
      port_if.pin_o <= val;
      port_if.pin_oe_n <= ~(~val | next_boost);
      port_if.weak_pu <= val;
      port_if.boost <= next_boost;
      for (int b = 0; b < W; b++) begin
        cnt[b] <= next_cnt[b];
      end
    end
  end

endmodule // qbp_pin_drv

// [hw/qbp_port_top.sv]
// qbp_port_top.sv: latches, read paths and pin logic of ports 1, 3 and 4
`include "qbp_params.svh"

// Function
// - a set port-3 latch bit pulls its pin weakly high once the rise boost ends
// - port-3 alternates need latch one, except serial transmit and write strobe
// - port-4 CAN receive sees the line only with its latch bit set
// - port-3 bits map to serial, interrupt, timer, select and strobe functions
// - port-4 bits map to CAN transmit, CAN receive, MISO, SCK, MOSI
// - each bit is a D latch loaded from the bus on a write strobe
// - latch read returns latch outputs, pin read returns sampled pin levels
// - read-modify-write reads use the latch path, other reads the pin path
// - every bit is input or output on its own, no shared direction
// - output pin follows latch; writing one releases the pull-down
// - with latch set the alternate output decides the level, as an AND
// - reset sets every latch bit to one
// - after a latch rise the strong pull-up is on for two oscillator periods
module qbp_port_top #(
  parameter int P1_W = `QBP_P1_W,
  parameter int P3_W = `QBP_P3_W,
  parameter int P4_W = `QBP_P4_W,
  parameter int BOOST_CYC = `QBP_BOOST_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  // internal cpu bus
  input wire logic [1:0] port_sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rmw_i,
  input wire logic [`QBP_BUS_W-1:0] wdata_i,
  output logic [`QBP_BUS_W-1:0] rdata_o,
  output logic rvalid_o,
  // port 1 pins
  input wire logic [P1_W-1:0] p1_pin_i,
  output logic [P1_W-1:0] p1_pin_o,
  output logic [P1_W-1:0] p1_pin_oe_n_o,
  output logic [P1_W-1:0] p1_weak_pu_o,
  output logic [P1_W-1:0] p1_boost_o,
  // port 3 pins
  input wire logic [P3_W-1:0] p3_pin_i,
  output logic [P3_W-1:0] p3_pin_o,
  output logic [P3_W-1:0] p3_pin_oe_n_o,
  output logic [P3_W-1:0] p3_weak_pu_o,
  output logic [P3_W-1:0] p3_boost_o,
  // port 4 pins
  input wire logic [P4_W-1:0] p4_pin_i,
  output logic [P4_W-1:0] p4_pin_o,
  output logic [P4_W-1:0] p4_pin_oe_n_o,
  output logic [P4_W-1:0] p4_weak_pu_o,
  output logic [P4_W-1:0] p4_boost_o,
  // alternate outputs from peripherals, high when idle; the two active flags are low when idle
  input wire logic [P1_W-1:0] p1_alt_out_i,
  input wire logic ser_rx_out_i,
  input wire logic ser_tx_out_i,
  input wire logic ser_tx_active_i,
  input wire logic ext_wr_strobe_n_i,
  input wire logic ext_wr_active_i,
  input wire logic ext_rd_strobe_n_i,
  input wire logic can_tx_out_i,
  input wire logic spi_miso_out_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_mosi_out_i,
  // alternate inputs to peripherals
  output logic [P1_W-1:0] p1_alt_in_o,
  output logic ser_rx_in_o,
  output logic ser_clk_in_o,
  output logic ext_irq_zero_in_o,
  output logic ext_irq_one_in_o,
  output logic timer_zero_count_in_o,
  output logic timer_one_count_in_o,
  output logic spi_ss_in_o,
  output logic can_rx_in_o,
  output logic spi_miso_in_o,
  output logic spi_sck_in_o,
  output logic spi_mosi_in_o
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [P1_W-1:0] port_latch_byte_p1;
  logic [P3_W-1:0] port_latch_byte_p3;
  logic [P4_W-1:0] port_latch_byte_p4;
  logic [P1_W-1:0] p1_sync;
  logic [P3_W-1:0] p3_sync;
  logic [P4_W-1:0] p4_sync;
  logic [P3_W-1:0] p3_alt_val;
  logic [P3_W-1:0] p3_force;
  logic [P4_W-1:0] p4_alt_val;
  logic sel_p1;
  logic sel_p3;
  logic sel_p4;
  logic wr_p1;
  logic wr_p3;
  logic wr_p4;
  logic [`QBP_BUS_W-1:0] lat_sel;
  logic [`QBP_BUS_W-1:0] pin_sel;
  logic [`QBP_BUS_W-1:0] next_rdata;

  qbp_drv_if #(.W(P1_W)) p1_if ();
  qbp_drv_if #(.W(P3_W)) p3_if ();
  qbp_drv_if #(.W(P4_W)) p4_if ();

  // --------------------------------------------------------------------------
  // port select decode
  // --------------------------------------------------------------------------
  // true when the bus select names the given port
  function automatic logic sel_hit(input logic [1:0] sel, input qbp_pkg::qbp_sel_t which);
    return qbp_pkg::qbp_sel_t'(sel) == which;
  endfunction

  // one flag per port, shared by the write strobes and both read views
  assign sel_p1 = sel_hit(port_sel_i, qbp_pkg::QBP_SEL_P1);
  assign sel_p3 = sel_hit(port_sel_i, qbp_pkg::QBP_SEL_P3);
  assign sel_p4 = sel_hit(port_sel_i, qbp_pkg::QBP_SEL_P4);

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  // one strobe per port, unmapped selection writes nothing
  assign wr_p1 = wr_i && sel_p1;
  assign wr_p3 = wr_i && sel_p3;
  assign wr_p4 = wr_i && sel_p4;

  // --------------------------------------------------------------------------
  // port latches
  // --------------------------------------------------------------------------
  // each bit is its own latch, so each line picks its direction alone
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      port_latch_byte_p1 <= P1_W'(`QBP_LATCH_RST);
      port_latch_byte_p3 <= P3_W'(`QBP_LATCH_RST);
      port_latch_byte_p4 <= P4_W'(`QBP_LATCH_RST);
    end else begin
      if (wr_p1) begin
        port_latch_byte_p1 <= wdata_i[P1_W-1:0];
      end
      if (wr_p3) begin
        port_latch_byte_p3 <= wdata_i[P3_W-1:0];
      end
      if (wr_p4) begin
        port_latch_byte_p4 <= wdata_i[P4_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  // every consumer of a pin level sees the second stage only
  qbp_sync #(.W(P1_W)) u_sync_p1 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(p1_pin_i),
    .sync_o(p1_sync)
  );

  qbp_sync #(.W(P3_W)) u_sync_p3 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(p3_pin_i),
    .sync_o(p3_sync)
  );

  qbp_sync #(.W(P4_W)) u_sync_p4 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(p4_pin_i),
    .sync_o(p4_sync)
  );

  // --------------------------------------------------------------------------
  // read paths
  // --------------------------------------------------------------------------
  // latch view and pin view of the selected port, unused upper bits zero
  assign lat_sel = sel_p1 ?
                   `QBP_BUS_W'(port_latch_byte_p1) :
                   sel_p3 ?
                   `QBP_BUS_W'(port_latch_byte_p3) :
                   sel_p4 ?
                   `QBP_BUS_W'(port_latch_byte_p4) : `QBP_RDATA_RST;
  assign pin_sel = sel_p1 ?
                   `QBP_BUS_W'(p1_sync) :
                   sel_p3 ?
                   `QBP_BUS_W'(p3_sync) :
                   sel_p4 ?
                   `QBP_BUS_W'(p4_sync) : `QBP_RDATA_RST;
  // read-modify-write operands come from the latch, avoiding loaded-pin errors
  assign next_rdata = rmw_i ? lat_sel : pin_sel;

  // read data register, one cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rdata_o <= `QBP_RDATA_RST;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // alternate output selection
  // --------------------------------------------------------------------------
  // port 3: only the serial transmit and write strobe override a cleared latch
  assign p3_alt_val = {ext_rd_strobe_n_i, ext_wr_strobe_n_i, 4'hf,
                       ser_tx_out_i, ser_rx_out_i};
  assign p3_force = `QBP_P3_FORCE_MASK &
                    {1'b0, ext_wr_active_i, 4'h0, ser_tx_active_i, 1'b0};
  // port 4: the CAN receive position stays released
  assign p4_alt_val = {spi_mosi_out_i, spi_sck_out_i, spi_miso_out_i,
                       1'b1, can_tx_out_i};

  // driver bank inputs
  assign p1_if.latch = port_latch_byte_p1;
  assign p1_if.alt_val = p1_alt_out_i;
  assign p3_if.latch = port_latch_byte_p3 | p3_force;
  assign p3_if.alt_val = p3_alt_val;
  assign p4_if.latch = port_latch_byte_p4;
  assign p4_if.alt_val = p4_alt_val;

  // --------------------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------------------
  qbp_pin_drv #(.W(P1_W), .BOOST_CYC(BOOST_CYC)) u_drv_p1 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port_if(p1_if.drv)
  );

  qbp_pin_drv #(.W(P3_W), .BOOST_CYC(BOOST_CYC)) u_drv_p3 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port_if(p3_if.drv)
  );

  qbp_pin_drv #(.W(P4_W), .BOOST_CYC(BOOST_CYC)) u_drv_p4 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .port_if(p4_if.drv)
  );

  // registered pin outputs of the driver banks
  assign p1_pin_o = p1_if.pin_o;
  assign p1_pin_oe_n_o = p1_if.pin_oe_n;
  assign p1_weak_pu_o = p1_if.weak_pu;
  assign p1_boost_o = p1_if.boost;
  assign p3_pin_o = p3_if.pin_o;
  assign p3_pin_oe_n_o = p3_if.pin_oe_n;
  assign p3_weak_pu_o = p3_if.weak_pu;
  assign p3_boost_o = p3_if.boost;
  assign p4_pin_o = p4_if.pin_o;
  assign p4_pin_oe_n_o = p4_if.pin_oe_n;
  assign p4_weak_pu_o = p4_if.weak_pu;
  assign p4_boost_o = p4_if.boost;

  // --------------------------------------------------------------------------
  // alternate inputs
  // --------------------------------------------------------------------------
  // synchronised pin levels, held idle high while the latch bit is clear, except the ungated serial clock input
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      p1_alt_in_o <= '1;
      ser_rx_in_o <= `QBP_ALT_IN_IDLE;
      ser_clk_in_o <= `QBP_ALT_IN_IDLE;
      ext_irq_zero_in_o <= `QBP_ALT_IN_IDLE;
      ext_irq_one_in_o <= `QBP_ALT_IN_IDLE;
      timer_zero_count_in_o <= `QBP_ALT_IN_IDLE;
      timer_one_count_in_o <= `QBP_ALT_IN_IDLE;
      spi_ss_in_o <= `QBP_ALT_IN_IDLE;
      can_rx_in_o <= `QBP_ALT_IN_IDLE;
      spi_miso_in_o <= `QBP_ALT_IN_IDLE;
      spi_sck_in_o <= `QBP_ALT_IN_IDLE;
      spi_mosi_in_o <= `QBP_ALT_IN_IDLE;
    end else begin
      p1_alt_in_o <= p1_sync | ~port_latch_byte_p1;
      ser_rx_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p3[`QBP_P3_SER_RX],
                                       p3_sync[`QBP_P3_SER_RX]);
      ser_clk_in_o <= p3_sync[`QBP_P3_SER_TX];
      ext_irq_zero_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p3[`QBP_P3_IRQ0],
                                             p3_sync[`QBP_P3_IRQ0]);
      ext_irq_one_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p3[`QBP_P3_IRQ1],
                                            p3_sync[`QBP_P3_IRQ1]);
      timer_zero_count_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p3[`QBP_P3_T0],
                                                 p3_sync[`QBP_P3_T0]);
      timer_one_count_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p3[`QBP_P3_T1_SS],
                                                p3_sync[`QBP_P3_T1_SS]);
      spi_ss_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p3[`QBP_P3_T1_SS],
                                       p3_sync[`QBP_P3_T1_SS]);
      can_rx_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p4[`QBP_P4_CAN_RX],
                                       p4_sync[`QBP_P4_CAN_RX]);
      spi_miso_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p4[`QBP_P4_MISO],
                                         p4_sync[`QBP_P4_MISO]);
      spi_sck_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p4[`QBP_P4_SCK],
                                        p4_sync[`QBP_P4_SCK]);
      spi_mosi_in_o <= qbp_pkg::qbp_gate(port_latch_byte_p4[`QBP_P4_MOSI],
                                         p4_sync[`QBP_P4_MOSI]);
    end
  end

endmodule // qbp_port_top

// [dv/qbp_port_top_sva.sv]
// qbp_port_top_sva.sv: concurrent checks on the port block ports
`include "qbp_params.svh"

module qbp_port_chk #(
  parameter int P1_W = 8,
  parameter int P3_W = 8,
  parameter int P4_W = 5
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [1:0] port_sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rmw_i,
  input wire logic [`QBP_BUS_W-1:0] wdata_i,
  input wire logic [`QBP_BUS_W-1:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [P1_W-1:0] p1_pin_i,
  input wire logic [P1_W-1:0] p1_pin_o,
  input wire logic [P1_W-1:0] p1_alt_out_i,
  input wire logic [P3_W-1:0] p3_pin_i,
  input wire logic [P3_W-1:0] p3_pin_o,
  input wire logic [P3_W-1:0] p3_pin_oe_n_o,
  input wire logic [P3_W-1:0] p3_weak_pu_o,
  input wire logic [P3_W-1:0] p3_boost_o,
  input wire logic [P4_W-1:0] p4_pin_i,
  input wire logic [P4_W-1:0] p4_pin_o,
  input wire logic ser_tx_out_i,
  input wire logic ser_tx_active_i,
  input wire logic ser_clk_in_o,
  input wire logic ext_irq_zero_in_o,
  input wire logic can_rx_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // --------------------------------------------------------------------------
  // bus side
  // --------------------------------------------------------------------------
  rd_valid_a: assert property (rd_i |=> rvalid_o)
    else $error("read without rvalid");
  rv_cause_a: assert property (rvalid_o |-> $past(rd_i))
    else $error("rvalid without read");
  pin_rd_a: assert property (rd_i && !rmw_i && port_sel_i == 2'h0 |=>
    rdata_o == $past(p1_pin_i, 3)) else $error("pin read value wrong");
  none_rd_a: assert property (rd_i && port_sel_i == 2'h3 |=> rdata_o == 8'h00)
    else $error("unselected read not zero");
  rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without read");
  wr_pin_a: assert property (wr_i && port_sel_i == 2'h0 ##1 !(wr_i && port_sel_i == 2'h0)
    |=> p1_pin_o == ($past(wdata_i, 2) & $past(p1_alt_out_i))) else $error("pin not latch and alt");

  // --------------------------------------------------------------------------
  // pin drivers and alternate inputs
  // --------------------------------------------------------------------------
  boost_on_a: assert property ($rose(p3_pin_o[0]) |-> p3_boost_o[0] ##1
    (p3_boost_o[0] || !p3_pin_o[0])) else $error("boost short");
  boost_off_a: assert property (p3_pin_o[0] [*3] |-> !p3_boost_o[0])
    else $error("boost long");
  oe_drive_a: assert property (p3_pin_oe_n_o == ~(~p3_pin_o | p3_boost_o))
    else $error("output enable wrong");
  weak_rel_a: assert property ((p3_pin_oe_n_o & ~p3_weak_pu_o) == 8'h00)
    else $error("released pin lacks weak pull-up");
  can_gate_a: assert property (!p4_pin_o[1] [*3] |-> can_rx_in_o)
    else $error("can receive seen with latch clear");
  can_pass_a: assert property (p4_pin_o[1] [*6] |-> can_rx_in_o == $past(p4_pin_i[1], 3))
    else $error("can receive not following pin");
  irq_gate_a: assert property (!p3_pin_o[2] [*3] |-> ext_irq_zero_in_o)
    else $error("interrupt seen with latch clear");
  clk_free_a: assert property (ser_clk_in_o == $past(p3_pin_i[1], 3))
    else $error("serial clock input gated");
  tx_bypass_a: assert property (ser_tx_active_i |=> p3_pin_o[1] == $past(ser_tx_out_i))
    else $error("transmit not bypassing latch");
  rst_val_a: assert property (disable iff (1'b0) !resetn_i |=> p1_pin_o == '1 &&
    !rvalid_o && p3_boost_o == 8'h00) else $error("reset state wrong");

  // main scenarios
  cover property (wr_i && port_sel_i == 2'h1);
  cover property (rd_i && !rmw_i && port_sel_i == 2'h0);
  cover property ($rose(p3_pin_o[0]));
  cover property (ser_tx_active_i);
endmodule // qbp_port_chk

bind qbp_port_top qbp_port_chk #(.P1_W(P1_W), .P3_W(P3_W), .P4_W(P4_W)) chk_u (.*);

// [dv/qbp_pin_env.sv]
// qbp_pin_env.sv: outside pins with pull-ups and optional pull-low drivers
module qbp_pin_env #(
  parameter int W = 8
) (
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] pull_lo_i,
  output logic [W-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven bits show the drive, released bits sit high unless pulled low
  assign pin_o = (~oe_n_i & drv_i) | (oe_n_i & ~pull_lo_i);
endmodule // qbp_pin_env

// [dv/qbp_port_top_tb.sv]
// qbp_port_top_tb.sv: self-checking bench of the port block
module qbp_port_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------------------
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] port_sel_i = 2'h3;
  logic wr_i = 1'b0, rd_i = 1'b0, rmw_i = 1'b0, rvalid_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, p1_alt_out_i = 8'hff, alt8 = 8'hff;
  logic [7:0] p1_pin_i, p1_pin_o, p1_pin_oe_n_o, p1_weak_pu_o, p1_boost_o, p1_alt_in_o;
  logic [7:0] p3_pin_i, p3_pin_o, p3_pin_oe_n_o, p3_weak_pu_o, p3_boost_o;
  logic [4:0] p4_pin_i, p4_pin_o, p4_pin_oe_n_o, p4_weak_pu_o, p4_boost_o;
  logic [7:0] lo1 = 8'h00, lo3 = 8'h00;
  logic [4:0] lo4 = 5'h00;
  logic ser_tx_active_i = 1'b0, ext_wr_active_i = 1'b0;
  logic ser_rx_in_o, ser_clk_in_o, ext_irq_zero_in_o, ext_irq_one_in_o, spi_ss_in_o;
  logic timer_zero_count_in_o, timer_one_count_in_o, can_rx_in_o;
  logic spi_miso_in_o, spi_sck_in_o, spi_mosi_in_o;
  wire logic ser_rx_out_i = alt8[0];
  wire logic ser_tx_out_i = alt8[1];
  wire logic ext_wr_strobe_n_i = alt8[2];
  wire logic ext_rd_strobe_n_i = alt8[3];
  wire logic can_tx_out_i = alt8[4];
  wire logic spi_miso_out_i = alt8[5];
  wire logic spi_sck_out_i = alt8[6];
  wire logic spi_mosi_out_i = alt8[7];
  int errors = 0;
  int tests_run = 0;

  always #4 clock_i = ~clock_i;

  qbp_port_top dut_u (.*);
  qbp_pin_env #(.W(8)) env1_u (.drv_i(p1_pin_o), .oe_n_i(p1_pin_oe_n_o), .pull_lo_i(lo1),
    .pin_o(p1_pin_i));
  qbp_pin_env #(.W(8)) env3_u (.drv_i(p3_pin_o), .oe_n_i(p3_pin_oe_n_o), .pull_lo_i(lo3),
    .pin_o(p3_pin_i));
  qbp_pin_env #(.W(5)) env4_u (.drv_i(p4_pin_o), .oe_n_i(p4_pin_oe_n_o), .pull_lo_i(lo4),
    .pin_o(p4_pin_i));

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clock_i);
    port_sel_i = s;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clock_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [1:0] s, input logic m, output logic [7:0] d);
    @(negedge clock_i);
    port_sel_i = s;
    rmw_i = m;
    rd_i = 1'b1;
    @(negedge clock_i);
    rd_i = 1'b0;
    cmp({7'h00, rvalid_o}, 8'h01);
    d = rdata_o;
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    cmp(p1_pin_o, 8'hff);
    cmp(p3_weak_pu_o, 8'hff);
    cmp(p3_boost_o, 8'h00);
    cmp({3'h0, p4_pin_o}, 8'h1f);
    cmp(rdata_o, 8'h00);
    cmp(p1_weak_pu_o, 8'hff);
    cmp(p1_boost_o, 8'h00);
    cmp({3'h0, p4_pin_oe_n_o}, 8'h1f);
    cmp({3'h0, p4_weak_pu_o}, 8'h1f);
    cmp({3'h0, p4_boost_o}, 8'h00);
  endtask
  task automatic t_latch;
    logic [7:0] d;
    wr(2'h0, 8'ha5);
    rd(2'h0, 1'b1, d);
    cmp(d, 8'ha5);
    cmp(p1_pin_oe_n_o, 8'ha5);
    wr(2'h2, 8'hea);
    rd(2'h2, 1'b1, d);
    cmp(d, 8'h0a);
    wr(2'h1, 8'h3c);
    wr(2'h1, 8'hc3);
    wr(2'h3, 8'h00);
    rd(2'h1, 1'b1, d);
    cmp(d, 8'hc3);
    rd(2'h3, 1'b0, d);
    cmp(d, 8'h00);
    wr(2'h1, 8'hff);
    wr(2'h2, 8'hff);
  endtask
  task automatic t_pins;
    logic [7:0] d;
    wr(2'h0, 8'h0f);
    lo1 = 8'h33;
    cyc(5);
    rd(2'h0, 1'b0, d);
    cmp(d, 8'h0c);
    rd(2'h0, 1'b1, d);
    cmp(d, 8'h0f);
    cmp(p1_alt_in_o, 8'hfc);
    lo1 = 8'h00;
    wr(2'h0, 8'hff);
  endtask
  task automatic t_boost;
    wr(2'h1, 8'h00);
    cyc(2);
    cmp(p3_pin_oe_n_o, 8'h00);
    wr(2'h1, 8'h01);
    cyc(1);
    cmp(p3_boost_o, 8'h01);
    cmp(p3_pin_o, 8'h01);
    cyc(1);
    cmp(p3_boost_o, 8'h01);
    cyc(1);
    cmp(p3_boost_o, 8'h00);
    cmp(p3_pin_oe_n_o, 8'h01);
    ser_tx_active_i = 1'b1;
    cyc(2);
    cmp({7'h0, p3_pin_o[1]}, 8'h01);
    ser_tx_active_i = 1'b0;
    cyc(2);
    cmp({7'h0, p3_pin_o[1]}, 8'h00);
    lo3 = 8'h04;
    cyc(5);
    cmp({7'h0, ext_irq_zero_in_o}, 8'h01);
    wr(2'h1, 8'hff);
    cyc(7); // boost holds the pin high two cycles, then three stages to the input
    cmp({7'h0, ext_irq_zero_in_o}, 8'h00);
    lo3 = 8'h00;
    wr(2'h2, 8'h1d);
    lo4 = 5'h02;
    cyc(5);
    cmp({7'h0, can_rx_in_o}, 8'h01);
    wr(2'h2, 8'h1f);
    cyc(7); // boost on the rising latch bit delays the pulled-low level
    cmp({7'h0, can_rx_in_o}, 8'h00);
    lo4 = 5'h00;
  endtask
  task automatic t_map;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      lo3 = 8'h01 << i;
      lo4 = lo3[4:0];
      cyc(5);
      m = ~lo3;
      cmp({1'b0, spi_ss_in_o, timer_one_count_in_o, timer_zero_count_in_o, ext_irq_one_in_o,
        ext_irq_zero_in_o, ser_clk_in_o, ser_rx_in_o}, {1'b0, m[5], m[5:0]});
      cmp({4'h0, spi_mosi_in_o, spi_sck_in_o, spi_miso_in_o, can_rx_in_o}, {4'h0, m[4:1]});
    end
    lo3 = 8'h00;
    lo4 = 5'h00;
    for (int k = 0; k < 8; k++) begin
      alt8 = ~(8'h01 << k);
      cyc(2);
      m = alt8;
      cmp(p3_pin_o, {m[3], m[2], 4'hf, m[1], m[0]});
      cmp({3'h0, p4_pin_o}, {3'h0, m[7], m[6], m[5], 1'b1, m[4]});
    end
    alt8 = 8'hff;
    p1_alt_out_i = 8'h3c;
    cyc(2);
    cmp(p1_pin_o, 8'h3c);
    p1_alt_out_i = 8'hff;
  endtask

  // main sequence: reset held 20 cycles, then every scenario
  initial begin
    cyc(20);
    resetn_i = 1'b1;
    cyc(1);
    t_reset;
    t_latch;
    t_pins;
    t_boost;
    t_map;
    tally_and_finish;
  end

  // watchdog far beyond the roughly 160 cycles the scenarios need
  initial begin
    #32000;
    errors++;
    tally_and_finish;
  end
endmodule // qbp_port_top_tb
